// [csr_pkg.sv]
// Operation
// - Two 16-bit pointers, separately addressable bytes.
// - Select bit zero picks active pointer.
// - Pointer users see currently selected pointer.
// - Four banks of eight working registers.
// - Banks also reachable at 0xFF00-0xFF1F.
// - Status bits 4:3 hold the bank select field; working register addressing does not use them.
// - Status bit 7 is arithmetic carry/borrow.
// - Status bit 6 is nibble carry/borrow.
// - Status bit 2 is arithmetic overflow.
// - Status bit 0 tracks accumulator parity.
// - Status bits 5,1 are software-only flags.
// - Status word at 0xD0, bit addressable.
// - Accumulator is operand and register 0xE0.
// - B supplies multiply/divide second operand.
package csr_pkg;
  localparam logic [7:0] CSR_ADDR_PTR0_LO = 8'h82;
  localparam logic [7:0] CSR_ADDR_PTR0_HI = 8'h83;
  localparam logic [7:0] CSR_ADDR_PTR1_LO = 8'h84;
  localparam logic [7:0] CSR_ADDR_PTR1_HI = 8'h85;
  localparam logic [7:0] CSR_ADDR_SEL = 8'h92;
  localparam logic [7:0] CSR_ADDR_STAT = 8'hD0;
  localparam logic [7:0] CSR_ADDR_ACC = 8'hE0;
  localparam logic [7:0] CSR_ADDR_B = 8'hF0;
  localparam logic [15:0] CSR_XWIN_BASE = 16'hFF00;
  localparam logic [15:0] CSR_XWIN_LAST = 16'hFF1F;
  localparam logic [7:0] CSR_RST_BYTE = 8'h00;
  localparam int CSR_BIT_CARRY = 7;
  localparam int CSR_BIT_NIBBLE = 6;
  localparam int CSR_BIT_USER0 = 5;
  localparam int CSR_BIT_BANK_HI = 4;
  localparam int CSR_BIT_BANK_LO = 3;
  localparam int CSR_BIT_EXCESS = 2;
  localparam int CSR_BIT_USER1 = 1;
  localparam int CSR_BIT_P = 0;
  // Flags that arithmetic results may update.
  localparam logic [7:0] CSR_ARITH_MASK = 8'hC4;
endpackage

// [csr_core_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs
  import csr_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Special-function byte access.
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Single-bit access to the status word.
  input wire logic stat_bit_wr,
  input wire logic [2:0] stat_bit_idx,
  input wire logic stat_bit_val,
  // Working register access from internal data space and external window.
  input wire logic wreg_wr,
  input wire logic wreg_xdata,
  input wire logic [15:0] wreg_addr,
  input wire logic [7:0] wreg_wdata,
  output logic [7:0] wreg_rdata,
  // Execution unit updates.
  input wire logic acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire logic arith_wr,
  input wire logic carry_in,
  input wire logic nibble_in,
  input wire logic excess_in,
  input wire logic dptr_wr,
  input wire logic [15:0] dptr_wdata,
  // Views for the execution unit.
  output logic [15:0] active_dptr,
  output logic [7:0] acc_q,
  output logic [7:0] b_q,
  output logic [7:0] status_q
);

  // Pointer byte registers, one pair per pointer.
  logic [7:0] ptr0_lo_ff;
  logic [7:0] ptr0_hi_ff;
  logic [7:0] ptr1_lo_ff;
  logic [7:0] ptr1_hi_ff;
  // Pointer select, status bits 7:1, accumulator and B.
  logic sel_ff;
  logic [6:0] stat_ff;
  logic [7:0] acc_ff;
  logic [7:0] b_ff;
  // Working register storage for all four banks.
  logic [7:0] bank_mem [0:31];
  // Registered read ports and execution-unit views.
  logic [7:0] rd_ff;
  logic [7:0] wrd_ff;
  logic [15:0] dptr_out_ff;
  logic [7:0] stat_out_ff;

  // Byte-write decode is used for every register, so it lives in one function.
  function automatic logic sfr_write_hit(input logic we, input logic [7:0] a,
                                         input logic [7:0] target);
    return we && (a == target);
  endfunction

  // Software writes win over the execution unit in the same cycle.
  wire w_ptr0_lo = sfr_write_hit(sfr_wr, sfr_addr, CSR_ADDR_PTR0_LO);
  wire w_ptr0_hi = sfr_write_hit(sfr_wr, sfr_addr, CSR_ADDR_PTR0_HI);
  wire w_ptr1_lo = sfr_write_hit(sfr_wr, sfr_addr, CSR_ADDR_PTR1_LO);
  wire w_ptr1_hi = sfr_write_hit(sfr_wr, sfr_addr, CSR_ADDR_PTR1_HI);
  wire w_sel = sfr_write_hit(sfr_wr, sfr_addr, CSR_ADDR_SEL);
  wire w_stat = sfr_write_hit(sfr_wr, sfr_addr, CSR_ADDR_STAT);
  wire w_acc = sfr_write_hit(sfr_wr, sfr_addr, CSR_ADDR_ACC);
  wire w_b = sfr_write_hit(sfr_wr, sfr_addr, CSR_ADDR_B);

  // Addresses that answer a read; everything else reads as zero.
  wire sfr_mapped = (sfr_addr == CSR_ADDR_PTR0_LO) || (sfr_addr == CSR_ADDR_PTR0_HI) ||
                    (sfr_addr == CSR_ADDR_PTR1_LO) || (sfr_addr == CSR_ADDR_PTR1_HI) ||
                    (sfr_addr == CSR_ADDR_SEL) || (sfr_addr == CSR_ADDR_STAT) ||
                    (sfr_addr == CSR_ADDR_ACC) || (sfr_addr == CSR_ADDR_B);

  // Pointer bytes; a software byte write beats an execution-unit load.
  // Only the pointer that is active at load time takes the load.
  wire [7:0] nxt_ptr0_lo = w_ptr0_lo ? sfr_wdata :
                           (dptr_wr && !sel_ff) ? dptr_wdata[7:0] : ptr0_lo_ff;
  wire [7:0] nxt_ptr0_hi = w_ptr0_hi ? sfr_wdata :
                           (dptr_wr && !sel_ff) ? dptr_wdata[15:8] : ptr0_hi_ff;
  wire [7:0] nxt_ptr1_lo = w_ptr1_lo ? sfr_wdata :
                           (dptr_wr && sel_ff) ? dptr_wdata[7:0] : ptr1_lo_ff;
  wire [7:0] nxt_ptr1_hi = w_ptr1_hi ? sfr_wdata :
                           (dptr_wr && sel_ff) ? dptr_wdata[15:8] : ptr1_hi_ff;
  wire nxt_sel = w_sel ? sfr_wdata[0] : sel_ff;
  wire [7:0] nxt_acc = w_acc ? sfr_wdata : acc_wr ? acc_wdata : acc_ff;
  wire [7:0] nxt_b = w_b ? sfr_wdata : b_ff;

  // Status word without parity: stat_ff[6:0] holds bits 7:1.
  // Parity is never stored, so software can never make it disagree with the accumulator.
  wire [7:0] stat_full = {stat_ff, 1'b0};
  wire [7:0] arith_val = {carry_in, nibble_in, 3'b000, excess_in, 2'b00};
  wire [7:0] stat_arith = arith_wr ? ((stat_full & ~CSR_ARITH_MASK) | (arith_val & CSR_ARITH_MASK))
                                   : stat_full;
  wire [7:0] bit_mask = 8'h01 << stat_bit_idx;
  wire [7:0] stat_bitw = stat_bit_wr ? ((stat_arith & ~bit_mask) | ({8{stat_bit_val}} & bit_mask))
                                     : stat_arith;
  wire [7:0] nxt_stat = w_stat ? sfr_wdata : stat_bitw;

  // Parity tracks the accumulator value being loaded this cycle.
  wire nxt_par = ^nxt_acc;
  wire [1:0] nxt_bank = nxt_stat[CSR_BIT_BANK_HI:CSR_BIT_BANK_LO];

  // Working register address: direct 5-bit index for data space, window for external.
  wire x_hit = wreg_addr >= CSR_XWIN_BASE && wreg_addr <= CSR_XWIN_LAST;
  wire d_hit = wreg_addr[15:5] == 11'h000;
  wire wreg_hit = wreg_xdata ? x_hit : d_hit;
  wire [4:0] wreg_idx = wreg_addr[4:0];

  // Byte read mux for the special-function port.
  // It reads next values so a write and a read in one cycle return the new byte.
  logic [7:0] nxt_rd;
  always_comb
  begin
    case (sfr_addr)
      CSR_ADDR_PTR0_LO: nxt_rd = nxt_ptr0_lo;
      CSR_ADDR_PTR0_HI: nxt_rd = nxt_ptr0_hi;
      CSR_ADDR_PTR1_LO: nxt_rd = nxt_ptr1_lo;
      CSR_ADDR_PTR1_HI: nxt_rd = nxt_ptr1_hi;
      CSR_ADDR_SEL: nxt_rd = {7'h00, nxt_sel};
      CSR_ADDR_STAT: nxt_rd = {nxt_stat[7:5], nxt_bank, nxt_stat[2:1], nxt_par};
      CSR_ADDR_ACC: nxt_rd = nxt_acc;
      CSR_ADDR_B: nxt_rd = nxt_b;
      default: nxt_rd = 8'h00;
    endcase
  end

  // Register update.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ptr0_lo_ff <= CSR_RST_BYTE;
      ptr0_hi_ff <= CSR_RST_BYTE;
      ptr1_lo_ff <= CSR_RST_BYTE;
      ptr1_hi_ff <= CSR_RST_BYTE;
      sel_ff <= 1'b0;
      stat_ff <= 7'h00;
      acc_ff <= CSR_RST_BYTE;
      b_ff <= CSR_RST_BYTE;
      rd_ff <= CSR_RST_BYTE;
      dptr_out_ff <= 16'h0000;
      stat_out_ff <= 8'h00;
    end
    else
    begin
      ptr0_lo_ff <= nxt_ptr0_lo;
      ptr0_hi_ff <= nxt_ptr0_hi;
      ptr1_lo_ff <= nxt_ptr1_lo;
      ptr1_hi_ff <= nxt_ptr1_hi;
      sel_ff <= nxt_sel;
      stat_ff <= nxt_stat[7:1];
      acc_ff <= nxt_acc;
      b_ff <= nxt_b;
      rd_ff <= nxt_rd;
      dptr_out_ff <= nxt_sel ? {nxt_ptr1_hi, nxt_ptr1_lo} : {nxt_ptr0_hi, nxt_ptr0_lo};
      stat_out_ff <= {nxt_stat[7:5], nxt_bank, nxt_stat[2:1], nxt_par};
    end
  end

  // Bank storage; no reset, contents are undefined until written.
  always_ff @(posedge core_clk)
  begin
    if (wreg_wr && wreg_hit)
    begin
      bank_mem[wreg_idx] <= wreg_wdata;
    end
  end

  // Registered bank read; out-of-range addresses read zero.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wrd_ff <= 8'h00;
    end
    else
    begin
      wrd_ff <= wreg_hit ? bank_mem[wreg_idx] : 8'h00;
    end
  end

  assign sfr_rdata = rd_ff;
  assign wreg_rdata = wrd_ff;
  assign active_dptr = dptr_out_ff;
  assign acc_q = acc_ff;
  assign b_q = b_ff;
  assign status_q = stat_out_ff;

  // Parity output always matches the accumulator.
  property p_parity;
    @(posedge core_clk) disable iff (rst) status_q[CSR_BIT_P] == ^acc_q;
  endproperty
  a_parity: assert property (p_parity) else $error("parity mismatch");

  // Selecting a pointer switches the view on the next cycle.
  property p_sel;
    @(posedge core_clk) disable iff (rst)
      w_sel |=> active_dptr == ($past(sfr_wdata[0]) ? {ptr1_hi_ff, ptr1_lo_ff}
                                                    : {ptr0_hi_ff, ptr0_lo_ff});
  endproperty
  a_sel: assert property (p_sel) else $error("pointer select wrong");

  // Arithmetic results land in the flags unless software writes the word; a status bit write overrides only its own bit.
  property p_carry;
    @(posedge core_clk) disable iff (rst)
      (arith_wr && !w_stat && !stat_bit_wr) |=> status_q[CSR_BIT_CARRY] == $past(carry_in);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");

  property p_nibble;
    @(posedge core_clk) disable iff (rst)
      (arith_wr && !w_stat && !stat_bit_wr) |=> status_q[CSR_BIT_NIBBLE] == $past(nibble_in);
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble flag wrong");

  property p_excess;
    @(posedge core_clk) disable iff (rst)
      (arith_wr && !w_stat && !stat_bit_wr) |=> status_q[CSR_BIT_EXCESS] == $past(excess_in);
  endproperty
  a_excess: assert property (p_excess) else $error("overflow flag wrong");

  // Hardware never touches the two user flags.
  property p_user;
    @(posedge core_clk) disable iff (rst)
      (!w_stat && !stat_bit_wr) |=> $stable({status_q[CSR_BIT_USER0], status_q[CSR_BIT_USER1]});
  endproperty
  a_user: assert property (p_user) else $error("user flag changed by hardware");

  property p_statw;
    @(posedge core_clk) disable iff (rst)
      w_stat |=> status_q[7:1] == $past(sfr_wdata[7:1]);
  endproperty
  a_statw: assert property (p_statw) else $error("status write lost");

  property p_bitw;
    @(posedge core_clk) disable iff (rst)
      (stat_bit_wr && !w_stat && stat_bit_idx != 3'd0) |=>
        status_q[$past(stat_bit_idx)] == $past(stat_bit_val);
  endproperty
  a_bitw: assert property (p_bitw) else $error("status bit write lost");

  // Without a load from either side the accumulator holds its value.
  property p_accw;
    @(posedge core_clk) disable iff (rst)
      (!w_acc && !acc_wr) |=> $stable(acc_q);
  endproperty
  a_accw: assert property (p_accw) else $error("accumulator changed unasked");

  property p_acc;
    @(posedge core_clk) disable iff (rst) w_acc |=> acc_q == $past(sfr_wdata);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator write lost");

  property p_bank;
    @(posedge core_clk) disable iff (rst)
      (wreg_wr && wreg_xdata && x_hit) ##1 (!wreg_wr && wreg_xdata && wreg_addr == $past(wreg_addr))
        |=> wreg_rdata == $past(wreg_wdata, 2);
  endproperty
  a_bank: assert property (p_bank) else $error("window read mismatch");

  property p_b;
    @(posedge core_clk) disable iff (rst) w_b |=> b_q == $past(sfr_wdata);
  endproperty
  a_b: assert property (p_b) else $error("B write lost");

  // B is plain scratch storage: it only changes on its own write.
  property p_b_hold;
    @(posedge core_clk) disable iff (rst)
      !w_b |=> $stable(b_q);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("B changed unasked");

  // Every view comes out of reset at zero.
  property p_rst;
    @(posedge core_clk)
      rst |=> (active_dptr == 16'h0000 && acc_q == CSR_RST_BYTE &&
               b_q == CSR_RST_BYTE && status_q == CSR_RST_BYTE);
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");

  // A status write sets the bank select field directly.
  property p_bank_sel;
    @(posedge core_clk) disable iff (rst)
      w_stat |=> status_q[CSR_BIT_BANK_HI:CSR_BIT_BANK_LO] == $past(sfr_wdata[4:3]);
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank select wrong");

  // With no load of any kind the active pointer view stays put.
  property p_ptr_hold;
    @(posedge core_clk) disable iff (rst)
      (!dptr_wr && !sfr_wr) |=> $stable(active_dptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed unasked");

  // An execution-unit pointer load shows up in the active pointer.
  property p_dptr_upd;
    @(posedge core_clk) disable iff (rst)
      (dptr_wr && !sfr_wr) |=> active_dptr == $past(dptr_wdata);
  endproperty
  a_dptr_upd: assert property (p_dptr_upd) else $error("pointer load lost");

  // The select bit only moves on its own write.
  property p_sel_hold;
    @(posedge core_clk) disable iff (rst)
      !w_sel |=> $stable(sel_ff);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed unasked");

  // Unmapped byte addresses read as zero.
  property p_unmapped;
    @(posedge core_clk) disable iff (rst)
      !sfr_mapped |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // External addresses outside the window read zero.
  property p_xwin;
    @(posedge core_clk) disable iff (rst)
      (wreg_xdata && !x_hit) |=> wreg_rdata == 8'h00;
  endproperty
  a_xwin: assert property (p_xwin) else $error("window miss not zero");

  // Data-space addresses above the four banks read zero.
  property p_dwin;
    @(posedge core_clk) disable iff (rst)
      (!wreg_xdata && !d_hit) |=> wreg_rdata == 8'h00;
  endproperty
  a_dwin: assert property (p_dwin) else $error("bank miss not zero");

endmodule // csr_core_regs
`default_nettype wire

// [csr_exec_model.sv]
`timescale 1ns/1ps
`default_nettype none
module csr_exec_model
(
  // Clock.
  input wire logic core_clk,
  // Updates sent to the register file.
  output logic acc_wr,
  output logic [7:0] acc_wdata,
  output logic arith_wr,
  output logic carry_in,
  output logic nibble_in,
  output logic excess_in,
  output logic dptr_wr,
  output logic [15:0] dptr_wdata
);
  // Strobes start low so nothing is written before the first operation.
  initial
  begin
    {acc_wr, arith_wr, dptr_wr, carry_in, nibble_in, excess_in} = 6'h00;
    acc_wdata = 8'h00;
    dptr_wdata = 16'h0000;
  end

  // Each update is a one-cycle pulse; data stays put after the pulse ends.
  task automatic load_acc(input logic [7:0] v);
    @(posedge core_clk) #1 {acc_wr, acc_wdata} = {1'b1, v};
    @(posedge core_clk) #1 acc_wr = 1'b0;
  endtask

  // Flag results of an arithmetic step, carry first.
  task automatic set_flags(input logic c, input logic n, input logic e);
    @(posedge core_clk) #1 {arith_wr, carry_in, nibble_in, excess_in} = {1'b1, c, n, e};
    @(posedge core_clk) #1 arith_wr = 1'b0;
  endtask

  // Pointer increments land in whichever pointer is active.
  task automatic load_dptr(input logic [15:0] v);
    @(posedge core_clk) #1 {dptr_wr, dptr_wdata} = {1'b1, v};
    @(posedge core_clk) #1 dptr_wr = 1'b0;
  endtask
endmodule // csr_exec_model
`default_nettype wire

// [cpu_core_special_registers_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module cpu_core_special_registers_tb;
  import csr_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} csr_row_type;
  logic core_clk, rst, sfr_wr, stat_bit_wr, stat_bit_val, wreg_wr, wreg_xdata;
  logic [7:0] sfr_addr, sfr_wdata, wreg_wdata;
  logic [2:0] stat_bit_idx;
  logic [15:0] wreg_addr;
  wire logic acc_wr, arith_wr, carry_in, nibble_in, excess_in, dptr_wr;
  wire logic [7:0] acc_wdata, sfr_rdata, wreg_rdata, acc_q, b_q, status_q;
  wire logic [15:0] dptr_wdata, active_dptr;
  int n_errors = 0;
  int checks_done = 0;
  // Address, written byte, expected read back; the last row is unmapped.
  csr_row_type rows [9] = '{'{8'h82, 8'hA5, 8'hA5}, '{8'h83, 8'h5A, 8'h5A},
    '{8'h84, 8'h3C, 8'h3C}, '{8'h85, 8'hC3, 8'hC3}, '{8'h92, 8'hFF, 8'h01},
    '{8'hE0, 8'h07, 8'h07}, '{8'hD0, 8'hFA, 8'hFB}, '{8'hF0, 8'h11, 8'h11},
    '{8'h90, 8'h55, 8'h00}};

  csr_core_regs dut (.core_clk(core_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .stat_bit_wr(stat_bit_wr),
    .stat_bit_idx(stat_bit_idx), .stat_bit_val(stat_bit_val), .wreg_wr(wreg_wr),
    .wreg_xdata(wreg_xdata), .wreg_addr(wreg_addr), .wreg_wdata(wreg_wdata),
    .wreg_rdata(wreg_rdata), .acc_wr(acc_wr), .acc_wdata(acc_wdata), .arith_wr(arith_wr),
    .carry_in(carry_in), .nibble_in(nibble_in), .excess_in(excess_in), .dptr_wr(dptr_wr),
    .dptr_wdata(dptr_wdata), .active_dptr(active_dptr), .acc_q(acc_q), .b_q(b_q),
    .status_q(status_q));
  csr_exec_model exec (.core_clk(core_clk), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
    .arith_wr(arith_wr), .carry_in(carry_in), .nibble_in(nibble_in), .excess_in(excess_in),
    .dptr_wr(dptr_wr), .dptr_wdata(dptr_wdata));

  // Free-running 250 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Byte write, then a read that lands one cycle after the address is set.
  task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(posedge core_clk) #1 sfr_wr = 1'b0;
  endtask
  task automatic sfr_get(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) #1 sfr_addr = a;
    @(posedge core_clk) #1 `CHK(sfr_rdata, e)
  endtask
  task automatic stat_put(input logic [2:0] i, input logic v);
    @(posedge core_clk) #1 {stat_bit_wr, stat_bit_idx, stat_bit_val} = {1'b1, i, v};
    @(posedge core_clk) #1 stat_bit_wr = 1'b0;
  endtask
  // Working register access; x picks the external window.
  task automatic w_put(input logic x, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk) #1 {wreg_wr, wreg_xdata, wreg_addr, wreg_wdata} = {1'b1, x, a, d};
    @(posedge core_clk) #1 wreg_wr = 1'b0;
  endtask
  task automatic w_get(input logic x, input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk) #1 {wreg_xdata, wreg_addr} = {x, a};
    @(posedge core_clk) #1 `CHK(wreg_rdata, e)
  endtask

  task automatic results;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // A hang past a generous bound counts as a failure.
  initial
  begin
    #20000;
    n_errors++;
    results();
  end

  // Main sequence: reset values, register table, then the corner cases.
  initial
  begin
    {rst, sfr_wr, stat_bit_wr, stat_bit_val, wreg_wr, wreg_xdata} = 6'h20;
    {sfr_addr, sfr_wdata, wreg_wdata, stat_bit_idx, wreg_addr} = 43'h0;
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    `CHK({active_dptr, acc_q, b_q, status_q}, 40'h0)
    foreach (rows[i]) sfr_get(rows[i].a, CSR_RST_BYTE);
    foreach (rows[i])
    begin
      sfr_put(rows[i].a, rows[i].d);
      sfr_get(rows[i].a, rows[i].e);
    end
    `CHK(active_dptr, 16'hC33C)
    `CHK(status_q[4:3], 2'b11)
    `CHK(b_q, 8'h11)
    sfr_put(CSR_ADDR_SEL, 8'h00);
    `CHK(active_dptr, 16'h5AA5)
    exec.load_dptr(16'h1234);
    sfr_get(CSR_ADDR_PTR0_LO, 8'h34);
    sfr_get(CSR_ADDR_PTR0_HI, 8'h12);
    sfr_get(CSR_ADDR_PTR1_LO, 8'h3C);
    // Single-bit writes; the parity bit ignores software.
    stat_put(3'd5, 1'b0);
    stat_put(3'd0, 1'b0);
    `CHK(status_q, 8'hDB)
    exec.set_flags(1'b0, 1'b1, 1'b0);
    `CHK(status_q, 8'h5B)
    exec.set_flags(1'b1, 1'b0, 1'b1);
    `CHK(status_q, 8'h9F)
    exec.load_acc(8'h03);
    `CHK({acc_q, status_q}, 16'h039E)
    // The same bank storage seen from both address spaces, then out-of-range accesses that read zero.
    w_put(1'b0, 16'h001F, 8'h77);
    w_get(1'b1, CSR_XWIN_LAST, 8'h77);
    w_put(1'b1, CSR_XWIN_BASE, 8'h99);
    w_get(1'b0, 16'h0000, 8'h99);
    w_put(1'b1, 16'hFF05, 8'h3E);
    w_get(1'b1, 16'hFF05, 8'h3E);
    w_put(1'b0, 16'h0020, 8'h66);
    w_get(1'b0, 16'h0020, 8'h00);
    w_get(1'b1, 16'hFF20, 8'h00);
    results();
  end
endmodule // cpu_core_special_registers_tb
`default_nettype wire
